// >>> inc/rdm_pkg.sv
// package: pin mapping codes, modes, source selectors and timing for the io mapper
package rdm_pkg;
  // operating modes of the radio
  typedef enum logic [2:0] {
    RDM_SLEEP,
    RDM_STDBY,
    RDM_SYNTH,
    RDM_RX,
    RDM_TX
  } rdm_mode_t;
  // internal sources that may reach a pin
  typedef enum logic [4:0] {
    SRC_NONE,
    SRC_REFERENCE_CLOCK_OUTPUT,
    SRC_MODE_READY,
    SRC_AUTO_MODE,
    SRC_LOCK,
    SRC_RX_READY,
    SRC_TX_READY,
    SRC_SYNC,
    SRC_TIMEOUT,
    SRC_RSSI,
    SRC_DATA,
    SRC_DCLK,
    SRC_Q_FULL,
    SRC_Q_NONEMPTY,
    SRC_Q_LEVEL,
    SRC_CRC_OK,
    SRC_PAYLOAD,
    SRC_SENT
  } rdm_src_t;
  localparam int RDM_PINS = 6;
  localparam int RDM_CODE_W = 2;
  localparam logic [1:0] MAP_00 = 2'h0;
  localparam logic [1:0] MAP_01 = 2'h1;
  localparam logic [1:0] MAP_10 = 2'h2;
  localparam logic [1:0] MAP_11 = 2'h3;
  // register a holds pins 3..0, register b pins 5..4 (lower nibble unused)
  localparam int MAP_A_W = 8;
  localparam int MAP_B_W = 8;
  localparam logic [7:0] MAP_A_RST = 8'h00;
  localparam logic [7:0] MAP_B_RST = 8'h00;
  // payload length limits
  localparam logic [7:0] LEN_MAX_PLAIN = 8'hFF;
  localparam logic [7:0] LEN_MAX_MSG_ENC = 8'h40;
  localparam logic [7:0] LEN_MAX_ADDR_ENC = 8'h41;
  localparam logic [7:0] LEN_MIN = 8'h01;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int DEF_BIT_DIV = 8;
endpackage

// >>> inc/rdm_sel_if.sv
// interface: selector codes passed from the mapper to the pin mux
`timescale 1ns/1ps
interface rdm_sel_if;
  import rdm_pkg::*;
  rdm_src_t sel [RDM_PINS]; // source chosen per pin
  logic [RDM_PINS-1:0] drive; // mapped pin drive level
  modport table_side (output sel, input drive);
  modport mux_side (input sel, output drive);
endinterface

// >>> core/rdm_pin_mux.sv
// module: per-pin multiplexer from selector code to a source level
`timescale 1ns/1ps
module rdm_pin_mux
  import rdm_pkg::*;
(
  rdm_sel_if.mux_side sel_bus,
  input wire logic [17:0] src_lvl
);
  // ----------------------------------------
  // one mux per pin
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < RDM_PINS; gi++)
    begin : g_pin
      // unmapped selects index 0 which is tied low
      assign sel_bus.drive[gi] = src_lvl[sel_bus.sel[gi]];
    end
  endgenerate
endmodule

// >>> core/rdm_io_mapper.sv
// module: io pin mapping and continuous/packet data path of the radio
`timescale 1ns/1ps
module rdm_io_mapper
  import rdm_pkg::*;
#(
  parameter int BIT_DIV = DEF_BIT_DIV
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire rdm_pkg::rdm_mode_t op_mode,
  input wire logic packet_mode,
  input wire logic bit_sync_en,
  input wire logic map_a_we,
  input wire logic [rdm_pkg::MAP_A_W-1:0] map_a_wdata,
  input wire logic map_b_we,
  input wire logic [rdm_pkg::MAP_B_W-1:0] map_b_wdata,
  input wire logic reference_clock_output,
  input wire logic mode_ready_flag,
  input wire logic automatic_mode_active,
  input wire logic synth_lock_flag,
  input wire logic receiver_ready_flag,
  input wire logic transmitter_ready_flag,
  input wire logic sync_match_flag,
  input wire logic timeout_flag,
  input wire logic rssi_flag,
  input wire logic queue_full_flag,
  input wire logic queue_nonempty_flag,
  input wire logic queue_threshold_flag,
  input wire logic checksum_good_flag,
  input wire logic payload_available_flag,
  input wire logic frame_sent_flag,
  input wire logic demod_raw_bit,
  input wire logic demod_clean_bit,
  input wire logic gp_pin_2_in,
  input wire logic length_format_select,
  input wire logic [7:0] programmed_frame_length,
  input wire logic aes_enable,
  input wire logic address_enable,
  output logic [rdm_pkg::RDM_PINS-1:0] gp_pin_out,
  output logic gp_pin_2_oe,
  output logic tx_mod_bit,
  output logic tx_bit_strobe,
  output logic queue_path_active,
  output logic bit_sync_active,
  output logic fixed_format_active,
  output logic frame_length_ok,
  output logic [7:0] map_a_rdata,
  output logic [7:0] map_b_rdata
);
  // ----------------------------------------
  // mapping registers
  // ----------------------------------------
  logic [MAP_A_W-1:0] map_a_q; // pin_map_register_a
  logic [MAP_A_W-1:0] map_a_d;
  logic [MAP_B_W-1:0] map_b_q; // pin_map_register_b
  logic [MAP_B_W-1:0] map_b_d;
  logic [RDM_CODE_W-1:0] code [RDM_PINS]; // per-pin code view

  // next register values on software write
  always_comb
  begin
    map_a_d = map_a_we ? map_a_wdata : map_a_q;
    map_b_d = map_b_we ? map_b_wdata : map_b_q;
  end

  // register the mapping codes
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      map_a_q <= MAP_A_RST;
      map_b_q <= MAP_B_RST;
    end
    else
    begin
      map_a_q <= map_a_d;
      map_b_q <= map_b_d;
    end
  end

  // pin 5,4 codes in register b; pin 3..0 in register a
  assign code[5] = map_b_q[7:6];
  assign code[4] = map_b_q[5:4];
  assign code[3] = map_a_q[7:6];
  assign code[2] = map_a_q[5:4];
  assign code[1] = map_a_q[3:2];
  assign code[0] = map_a_q[1:0];

  // ----------------------------------------
  // link inputs: two-flop synchronisers
  // ----------------------------------------
  logic [1:0] din_sync_q; // host data on pin 2
  logic [1:0] raw_sync_q; // demod raw bit is asynchronous to clk
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      din_sync_q <= 2'h0;
      raw_sync_q <= 2'h0;
    end
    else
    begin
      din_sync_q <= {din_sync_q[0], gp_pin_2_in};
      raw_sync_q <= {raw_sync_q[0], demod_raw_bit};
    end
  end

  // ----------------------------------------
  // data clock divider and data path
  // ----------------------------------------
  localparam int DIV_W = $clog2(BIT_DIV) + 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(BIT_DIV / 2);
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic dclk_q; // data clock level
  logic dclk_d;
  logic rx_bit_q; // cleaned rx bit held between falling edges
  logic rx_bit_d;
  logic tx_bit_q; // tx bit captured on rising edge
  logic tx_bit_d;
  logic tx_stb_q;
  logic tx_stb_d;
  // pin register plus the two pin-2 synchroniser flops
  localparam int CAP_LAG = 3;
  logic [CAP_LAG-1:0] dclk_dly_q; // data clock delayed to line up with synced host data
  logic [CAP_LAG-1:0] dclk_dly_d;
  logic in_rx_window_q; // between rx ready and payload rising edges
  logic in_rx_window_d;
  logic rxr_prev_q;
  logic pay_prev_q;
  logic sync_on;
  logic cont_tx;
  logic cont_rx;

  // bit sync is forced on in packet mode
  assign sync_on = packet_mode | bit_sync_en;
  assign cont_tx = !packet_mode && (op_mode == RDM_TX);
  assign cont_rx = !packet_mode && (op_mode == RDM_RX);

  // divider, data clock edges, capture and launch
  always_comb
  begin
    div_d = (div_q == DIV_LAST) ? '0 : div_q + DIV_W'(1);
    dclk_d = (div_q < DIV_HALF) ? 1'b0 : 1'b1;
    tx_bit_d = tx_bit_q;
    tx_stb_d = 1'b0;
    rx_bit_d = rx_bit_q;
    dclk_dly_d = {dclk_dly_q[CAP_LAG-2:0], dclk_q};
    // rising edge as the host sees it on the pin: an undelayed edge would
    // take the bit the host held before its last falling edge
    if (cont_tx && dclk_dly_q[CAP_LAG-2] && !dclk_dly_q[CAP_LAG-1])
    begin
      tx_bit_d = din_sync_q[1];
      tx_stb_d = 1'b1;
    end
    // falling edge: launch next cleaned rx bit
    if (dclk_q && !dclk_d)
      rx_bit_d = demod_clean_bit;
    in_rx_window_d = in_rx_window_q;
    // window opens on rx ready rise, closes on payload rise
    if (receiver_ready_flag && !rxr_prev_q)
      in_rx_window_d = 1'b1;
    if ((payload_available_flag && !pay_prev_q) || op_mode != RDM_RX)
      in_rx_window_d = 1'b0;
  end

  // data path registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      div_q <= '0;
      dclk_q <= 1'b0;
      rx_bit_q <= 1'b0;
      tx_bit_q <= 1'b0;
      tx_stb_q <= 1'b0;
      dclk_dly_q <= '0;
      in_rx_window_q <= 1'b0;
      rxr_prev_q <= 1'b0;
      pay_prev_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      dclk_q <= dclk_d;
      rx_bit_q <= rx_bit_d;
      tx_bit_q <= tx_bit_d;
      tx_stb_q <= tx_stb_d;
      dclk_dly_q <= dclk_dly_d;
      in_rx_window_q <= in_rx_window_d;
      rxr_prev_q <= receiver_ready_flag;
      pay_prev_q <= payload_available_flag;
    end
  end

  // ----------------------------------------
  // source levels and selection tables
  // ----------------------------------------
  logic [17:0] src_lvl;
  logic data_lvl;
  logic dclk_lvl;
  rdm_sel_if sel_bus ();

  // data source per mode
  always_comb
  begin
    data_lvl = 1'b0;
    dclk_lvl = 1'b0;
    if (packet_mode)
      data_lvl = in_rx_window_q & rx_bit_q;
    else if (cont_rx)
    begin
      // raw path without bit sync, no data clock
      data_lvl = sync_on ? rx_bit_q : raw_sync_q[1];
      dclk_lvl = sync_on & dclk_q;
    end
    else if (cont_tx)
      dclk_lvl = dclk_q;
  end

  always_comb
  begin
    src_lvl = '0; // index of none stays low
    src_lvl[SRC_REFERENCE_CLOCK_OUTPUT] = reference_clock_output;
    src_lvl[SRC_MODE_READY] = mode_ready_flag;
    src_lvl[SRC_AUTO_MODE] = automatic_mode_active;
    src_lvl[SRC_LOCK] = synth_lock_flag;
    src_lvl[SRC_RX_READY] = receiver_ready_flag;
    src_lvl[SRC_TX_READY] = transmitter_ready_flag;
    src_lvl[SRC_SYNC] = sync_match_flag;
    src_lvl[SRC_TIMEOUT] = timeout_flag;
    src_lvl[SRC_RSSI] = rssi_flag;
    src_lvl[SRC_DATA] = data_lvl;
    src_lvl[SRC_DCLK] = dclk_lvl;
    src_lvl[SRC_Q_FULL] = queue_full_flag;
    src_lvl[SRC_Q_NONEMPTY] = queue_nonempty_flag;
    src_lvl[SRC_Q_LEVEL] = queue_threshold_flag;
    src_lvl[SRC_CRC_OK] = checksum_good_flag;
    src_lvl[SRC_PAYLOAD] = payload_available_flag;
    src_lvl[SRC_SENT] = frame_sent_flag;
  end

  // table lookup per pin
  function automatic rdm_src_t pick(input int p, input logic [1:0] c, input rdm_mode_t m,
                                    input logic pk);
    rdm_src_t s;
    s = SRC_NONE;
    if (!pk)
    begin
      unique case (m)
        RDM_SLEEP, RDM_STDBY:
        begin
          if (c == MAP_00 && p == 5 && m == RDM_STDBY) s = SRC_REFERENCE_CLOCK_OUTPUT;
          if (c == MAP_10 && p == 3) s = SRC_AUTO_MODE;
          if (c == MAP_11 && (p == 5 || p == 0)) s = SRC_MODE_READY;
        end
        RDM_SYNTH:
        begin
          if (c == MAP_00 && p == 5) s = SRC_REFERENCE_CLOCK_OUTPUT;
          if (c == MAP_00 && p == 0) s = SRC_LOCK;
          if (c == MAP_10 && p == 3) s = SRC_AUTO_MODE;
          if (c == MAP_11) s = (p == 5 || p == 0) ? SRC_MODE_READY :
                               (p == 4 || p == 1) ? SRC_LOCK : SRC_NONE;
        end
        RDM_RX:
        begin
          unique case (c)
            MAP_00: s = p == 5 ? SRC_REFERENCE_CLOCK_OUTPUT : p == 4 ? SRC_TIMEOUT : p == 3 ? SRC_RSSI :
                        p == 2 ? SRC_DATA : p == 1 ? SRC_DCLK : SRC_SYNC;
            MAP_01: s = p == 5 ? SRC_RSSI : p == 2 ? SRC_DATA :
                        p == 0 ? SRC_TIMEOUT : SRC_RX_READY;
            MAP_10: s = p == 4 ? SRC_SYNC : p == 3 ? SRC_AUTO_MODE : p == 2 ? SRC_DATA :
                        p == 0 ? SRC_RSSI : SRC_NONE;
            MAP_11: s = p == 5 ? SRC_MODE_READY : p == 4 ? SRC_LOCK : p == 3 ? SRC_TIMEOUT :
                        p == 2 ? SRC_DATA : p == 1 ? SRC_SYNC : SRC_MODE_READY;
          endcase
        end
        RDM_TX:
        begin
          unique case (c)
            MAP_00: s = p == 5 ? SRC_REFERENCE_CLOCK_OUTPUT : p == 2 ? SRC_DATA : p == 1 ? SRC_DCLK :
                        p == 0 ? SRC_LOCK : SRC_TX_READY;
            MAP_01: s = p == 5 ? SRC_REFERENCE_CLOCK_OUTPUT : p == 2 ? SRC_DATA : SRC_TX_READY;
            MAP_10: s = p == 3 ? SRC_AUTO_MODE : p == 2 ? SRC_DATA : SRC_NONE;
            MAP_11: s = (p == 5 || p == 0) ? SRC_MODE_READY : p == 3 ? SRC_TX_READY :
                        p == 2 ? SRC_DATA : SRC_LOCK;
          endcase
        end
        default: s = SRC_NONE;
      endcase
    end
    else
    begin
      // pin 1 queue flags in every mode for codes 01/10
      if (c == MAP_01 && p == 1) s = SRC_Q_FULL;
      if (c == MAP_10 && p == 1) s = SRC_Q_NONEMPTY;
      if (c == MAP_00)
        s = p == 5 ? (m == RDM_SLEEP ? SRC_NONE : SRC_REFERENCE_CLOCK_OUTPUT) : p == 3 ? SRC_Q_FULL :
            p == 2 ? SRC_Q_NONEMPTY : p == 1 ? SRC_Q_LEVEL : SRC_NONE;
      if (c == MAP_11)
        s = p == 5 ? SRC_MODE_READY : p == 2 ? SRC_AUTO_MODE :
            (m == RDM_SLEEP || m == RDM_STDBY) ? SRC_NONE : SRC_LOCK;
      if (m == RDM_RX)
      begin
        if (c == MAP_00 && p == 4) s = SRC_TIMEOUT;
        if (c == MAP_00 && p == 0) s = SRC_CRC_OK;
        if (c == MAP_01 && p != 1) s = (p == 5 || p == 2) ? SRC_DATA :
                                       p == 0 ? SRC_PAYLOAD : SRC_RSSI;
        if (c == MAP_10 && (p == 3 || p == 0)) s = SRC_SYNC;
        if (c == MAP_10 && p == 4) s = SRC_RX_READY;
        if (c == MAP_11 && p == 1) s = SRC_TIMEOUT;
        if (c == MAP_11 && p == 0) s = SRC_RSSI;
      end
      if (m == RDM_TX)
      begin
        if (c == MAP_00 && p == 4) s = SRC_MODE_READY;
        if (c == MAP_00 && p == 0) s = SRC_SENT;
        if (c == MAP_01 && p != 1) s = (p == 5 || p == 2) ? SRC_DATA : SRC_TX_READY;
      end
    end
    return s;
  endfunction

  genvar gp;
  generate
    for (gp = 0; gp < RDM_PINS; gp++)
    begin : g_sel
      assign sel_bus.sel[gp] = pick(gp, code[gp], op_mode, packet_mode);
    end
  endgenerate

  rdm_pin_mux u_mux (
    .sel_bus (sel_bus.mux_side),
    .src_lvl (src_lvl)
  );

  // ----------------------------------------
  // output registers and packet format
  // ----------------------------------------
  logic [7:0] len_max;
  assign len_max = !aes_enable ? LEN_MAX_PLAIN :
                   address_enable ? LEN_MAX_ADDR_ENC : LEN_MAX_MSG_ENC;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      gp_pin_out <= '0;
      gp_pin_2_oe <= 1'b0;
      tx_mod_bit <= 1'b0;
      tx_bit_strobe <= 1'b0;
      queue_path_active <= 1'b0;
      bit_sync_active <= 1'b0;
      fixed_format_active <= 1'b0;
      frame_length_ok <= 1'b0;
      map_a_rdata <= MAP_A_RST;
      map_b_rdata <= MAP_B_RST;
    end
    else
    begin
      gp_pin_out <= sel_bus.drive;
      // pin 2 is an input while host sends tx data
      gp_pin_2_oe <= !(cont_tx && sel_bus.sel[2] == SRC_DATA);
      tx_mod_bit <= tx_bit_q;
      tx_bit_strobe <= tx_stb_q;
      queue_path_active <= packet_mode;
      bit_sync_active <= sync_on;
      fixed_format_active <= packet_mode && !length_format_select &&
                             programmed_frame_length != 8'h00;
      frame_length_ok <= programmed_frame_length >= LEN_MIN &&
                         programmed_frame_length <= len_max;
      map_a_rdata <= map_a_q;
      map_b_rdata <= map_b_q;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  pin_follows_map_a: assert property ($past(rstn) |-> gp_pin_out == $past(sel_bus.drive))
    else $error("pin not following mux");
  map_write_a: assert property (map_a_we |=> map_a_q == $past(map_a_wdata))
    else $error("map a write lost");
  none_low_a: assert property (sel_bus.sel[4] == SRC_NONE |=> !gp_pin_out[4])
    else $error("unmapped pin not low");
  rx00_pin2_a: assert property (cont_rx && code[2] == MAP_00 |->
    sel_bus.sel[2] == SRC_DATA)
    else $error("rx data not on pin 2");
  ptx_sent_a: assert property (packet_mode && op_mode == RDM_TX && code[0] == MAP_00
    && frame_sent_flag |=> gp_pin_out[0])
    else $error("sent flag not on pin 0");
  tx_cap_a: assert property (tx_stb_q |-> tx_bit_q == $past(din_sync_q[1]))
    else $error("tx capture wrong");
  nosync_clk_a: assert property (cont_rx && !bit_sync_en |-> !dclk_lvl)
    else $error("data clock without bit sync");
  pkt_win_a: assert property (packet_mode && !in_rx_window_q && sel_bus.sel[2] == SRC_DATA
    |=> !gp_pin_out[2])
    else $error("data outside window");
  pkt_close_a: assert property (packet_mode && op_mode == RDM_RX
    && $rose(payload_available_flag) |=> !in_rx_window_q)
    else $error("window not closed by payload");
  auto_pin3_a: assert property (!packet_mode && code[3] == MAP_10 |->
    sel_bus.sel[3] == SRC_AUTO_MODE)
    else $error("auto mode missing");
  cov_tx_cap: cover property (tx_stb_q);
  cov_win: cover property (in_rx_window_q ##1 !in_rx_window_q);
  cov_pkt_rx: cover property (packet_mode && op_mode == RDM_RX);
  cov_raw_rx: cover property (cont_rx && !sync_on);
endmodule

// >>> testbench/rdm_host_model.sv
// host side model: serial bit source and sink on the data clock and data pins
`timescale 1ns/1ps
module rdm_host_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic dclk,
  input wire logic pin2,
  input wire logic tx_on,
  output logic h_dat,
  output logic h_en,
  output logic rx_bit,
  output logic want_sync
);
  logic dclk_q; // data clock level one cycle back
  logic [7:0] pat_q; // outgoing pattern, msb leaves first
  // ------------------------------------------------------------
  // drive side
  // ------------------------------------------------------------
  assign want_sync = 1'b1;
  assign h_en = tx_on; // pin released outside transmit
  assign h_dat = pat_q[7];
  // ------------------------------------------------------------
  // data clock edge handling
  // ------------------------------------------------------------
  // new bit only after a falling edge, so capture edges see a still line
  always @(posedge clk)
  begin
    dclk_q <= dclk;
    if (!rstn)
    begin
      pat_q <= 8'hB4;
      rx_bit <= 1'b0;
    end
    else if (dclk_q && !dclk && tx_on)
      pat_q <= {pat_q[6:0], pat_q[7]};
    else if (!dclk_q && dclk)
      rx_bit <= pin2;
  end
endmodule

// >>> testbench/tb_rdm_io_mapper.sv
// testbench: pin mapping tables, serial data paths and length checks
`timescale 1ns/1ps
module tb_rdm_io_mapper;
  import rdm_pkg::*;
  // one table case: mode, code for every pin, expected, mapped, skipped
  typedef struct packed {logic pk; rdm_mode_t md; logic [1:0] cd;
    logic [5:0] e; logic [5:0] m; logic [5:0] x;} rdm_row_t;
  rdm_row_t rows [23] = '{
    '{1'b0, RDM_RX, 2'h0, 6'h30, 6'h39, 6'h06}, '{1'b0, RDM_RX, 2'h1, 6'h1B, 6'h3B, 6'h04},
    '{1'b0, RDM_TX, 2'h0, 6'h38, 6'h39, 6'h06}, '{1'b0, RDM_SLEEP, 2'h2, 6'h08, 6'h08, 6'h00},
    '{1'b0, RDM_RX, 2'h2, 6'h08, 6'h19, 6'h04}, '{1'b0, RDM_STDBY, 2'h3, 6'h00, 6'h21, 6'h00},
    '{1'b0, RDM_SYNTH, 2'h0, 6'h20, 6'h21, 6'h00}, '{1'b0, RDM_SYNTH, 2'h3, 6'h00, 6'h33, 6'h00},
    '{1'b1, RDM_SLEEP, 2'h0, 6'h08, 6'h0E, 6'h00}, '{1'b1, RDM_STDBY, 2'h0, 6'h28, 6'h2E, 6'h00},
    '{1'b1, RDM_SYNTH, 2'h1, 6'h02, 6'h02, 6'h00}, '{1'b1, RDM_TX, 2'h2, 6'h00, 6'h02, 6'h00},
    '{1'b1, RDM_RX, 2'h0, 6'h39, 6'h3F, 6'h00}, '{1'b1, RDM_RX, 2'h1, 6'h02, 6'h1B, 6'h24},
    '{1'b1, RDM_RX, 2'h2, 6'h10, 6'h1B, 6'h00}, '{1'b1, RDM_RX, 2'h3, 6'h06, 6'h3F, 6'h00},
    '{1'b1, RDM_TX, 2'h0, 6'h29, 6'h3F, 6'h00}, '{1'b1, RDM_TX, 2'h1, 6'h1B, 6'h1B, 6'h24},
    '{1'b1, RDM_SYNTH, 2'h3, 6'h04, 6'h3F, 6'h00},
    '{1'b0, RDM_TX, 2'h1, 6'h3B, 6'h3B, 6'h04}, '{1'b0, RDM_TX, 2'h3, 6'h08, 6'h3B, 6'h04},
    '{1'b0, RDM_RX, 2'h3, 6'h08, 6'h3B, 6'h04}, '{1'b1, RDM_SLEEP, 2'h3, 6'h04, 6'h24, 6'h00}};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  rdm_mode_t md = RDM_SLEEP;
  logic pk = 1'b0;
  logic no_bs = 1'b0; // forces the bit synchroniser request off
  logic we_a = 1'b0;
  logic we_b = 1'b0;
  logic [7:0] wd_a = 8'h00;
  logic [7:0] wd_b = 8'h00;
  logic [14:0] st = 15'h0000; // status sources, clock output at the top
  logic raw = 1'b0;
  logic cln = 1'b0;
  logic fsel = 1'b0;
  logic [7:0] flen = 8'h00;
  logic aes = 1'b0;
  logic adr = 1'b0;
  logic tx_on = 1'b0;
  logic flip = 1'b0; // undriven data line wanders, no pull on it
  logic [5:0] pins;
  logic oe, tbit, tstb, qpa, bsa, ffa, flo, h_dat, h_en, rx_bit, want, pin2_w;
  logic [7:0] rda, rdb;
  int bad_count = 0;
  int num_checks = 0;
  // ------------------------------------------------------------
  // clock, wire resolution, instances
  // ------------------------------------------------------------
  always #25 clk = ~clk;
  always @(posedge clk) flip <= ~flip;
  assign pin2_w = oe ? pins[2] : (h_en ? h_dat : flip);
  rdm_io_mapper u_dut (.clk(clk), .rstn(rstn), .op_mode(md), .packet_mode(pk),
    .bit_sync_en(want & ~no_bs), .map_a_we(we_a), .map_a_wdata(wd_a), .map_b_we(we_b),
    .map_b_wdata(wd_b), .reference_clock_output(st[14]), .mode_ready_flag(st[13]),
    .automatic_mode_active(st[12]), .synth_lock_flag(st[11]), .receiver_ready_flag(st[10]),
    .transmitter_ready_flag(st[9]), .sync_match_flag(st[8]), .timeout_flag(st[7]),
    .rssi_flag(st[6]), .queue_full_flag(st[5]), .queue_nonempty_flag(st[4]),
    .queue_threshold_flag(st[3]), .checksum_good_flag(st[2]),
    .payload_available_flag(st[1]), .frame_sent_flag(st[0]), .demod_raw_bit(raw),
    .demod_clean_bit(cln), .gp_pin_2_in(pin2_w), .length_format_select(fsel),
    .programmed_frame_length(flen), .aes_enable(aes), .address_enable(adr),
    .gp_pin_out(pins), .gp_pin_2_oe(oe), .tx_mod_bit(tbit), .tx_bit_strobe(tstb),
    .queue_path_active(qpa), .bit_sync_active(bsa), .fixed_format_active(ffa),
    .frame_length_ok(flo), .map_a_rdata(rda), .map_b_rdata(rdb));
  rdm_host_model u_host (.clk(clk), .rstn(rstn), .dclk(pins[1]), .pin2(pin2_w),
    .tx_on(tx_on), .h_dat(h_dat), .h_en(h_en), .rx_bit(rx_bit), .want_sync(want));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  // inputs always move one nanosecond after the rising edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  // same code on every pin; register b only carries pins 5 and 4
  task automatic wr_map(input logic [1:0] c);
    wd_a = {4{c}};
    wd_b = {c, c, 4'h0};
    we_a = 1'b1;
    we_b = 1'b1;
    tick();
    we_a = 1'b0;
    we_b = 1'b0;
  endtask
  task automatic ln(input logic s, input logic [7:0] l, input logic a, input logic d,
    input logic ef, input logic eo);
    fsel = s;
    flen = l;
    aes = a;
    adr = d;
    repeat (2) tick();
    chk(8'(ffa), 8'(ef), "fixed format");
    if (!s)
      chk(8'(flo), 8'(eo), "length limit");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------------------------
  // watchdog, far above the roughly 600 cycles the tests need
  // ------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("BAD at %0t: run hung", $time);
    stop_test();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rdm_row_t r;
    logic acc;
    logic seen;
    int n;
    repeat (3) tick();
    chk(8'(pins), 8'h00, "pins in reset");
    chk(rda | rdb, MAP_A_RST | MAP_B_RST, "map reset");
    rstn = 1'b1;
    // table rows, each source pattern and its inverse
    foreach (rows[i])
    begin
      r = rows[i];
      pk = r.pk;
      md = r.md;
      st = 15'h56A5;
      wr_map(r.cd);
      repeat (3) tick();
      chk(rda, {4{r.cd}}, "map a read");
      chk({rdb[7:4], 4'h0}, {r.cd, r.cd, 4'h0}, "map b read");
      chk(8'(pins & ~r.x), 8'(r.e & ~r.x), "pins");
      st = ~15'h56A5;
      repeat (2) tick();
      chk(8'(pins & ~r.x), 8'(~r.e & r.m), "pins inv");
    end
    // continuous transmit, host shifts bits against the data clock
    pk = 1'b0;
    md = RDM_TX;
    wr_map(2'h0);
    tx_on = 1'b1;
    // first captures may still hold the line from before the host drove it
    repeat (16) tick();
    n = 0;
    seen = 1'b0;
    repeat (200)
    begin
      tick();
      if (seen)
        chk(8'(tbit), 8'(h_dat), "tx bit");
      seen = (tstb === 1'b1);
      n += int'(seen);
    end
    chk(8'(n >= 20), 8'h01, "tx strobes");
    chk(8'(oe), 8'h00, "data pin released");
    tx_on = 1'b0;
    // continuous receive with bit synchroniser, host samples rising edges
    md = RDM_RX;
    cln = 1'b1;
    repeat (40) tick();
    chk(8'(rx_bit), 8'h01, "rx clean one");
    cln = 1'b0;
    repeat (40) tick();
    chk(8'(rx_bit), 8'h00, "rx clean zero");
    // synchroniser off: raw bits, data clock silent
    no_bs = 1'b1;
    raw = 1'b1;
    acc = 1'b0;
    repeat (40)
    begin
      tick();
      acc |= pins[1];
    end
    chk(8'(acc), 8'h00, "no data clock");
    chk(8'(pins[2]), 8'h01, "raw one");
    raw = 1'b0;
    repeat (8) tick();
    chk(8'(pins[2]), 8'h00, "raw zero");
    chk(8'(qpa) | 8'(bsa), 8'h00, "continuous path");
    // packet receive: data only between ready and payload edges
    pk = 1'b1;
    wr_map(2'h1);
    st = 15'h0000;
    cln = 1'b1;
    repeat (30) tick();
    chk(8'(pins[2]), 8'h00, "data before ready");
    chk(8'({qpa, bsa}), 8'h03, "packet path");
    st[10] = 1'b1;
    repeat (30) tick();
    chk(8'(pins[2]), 8'h01, "data in window");
    st[1] = 1'b1;
    repeat (30) tick();
    chk(8'(pins[2]), 8'h00, "data after payload");
    // length format and limits at their edges
    ln(1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    ln(1'b0, LEN_MIN, 1'b0, 1'b0, 1'b1, 1'b1);
    ln(1'b0, LEN_MAX_PLAIN, 1'b0, 1'b0, 1'b1, 1'b1);
    ln(1'b0, LEN_MAX_MSG_ENC, 1'b1, 1'b0, 1'b1, 1'b1);
    ln(1'b0, LEN_MAX_ADDR_ENC, 1'b1, 1'b0, 1'b1, 1'b0);
    ln(1'b0, LEN_MAX_ADDR_ENC, 1'b1, 1'b1, 1'b1, 1'b1);
    ln(1'b0, 8'h42, 1'b1, 1'b1, 1'b1, 1'b0);
    ln(1'b1, 8'h0A, 1'b0, 1'b0, 1'b0, 1'b0);
    // reset in mid-run: outputs clear, map codes back to reset value
    rstn = 1'b0;
    repeat (2) tick();
    chk({pins, oe, tstb}, 8'h00, "pins in mid reset");
    chk(8'({qpa, bsa, ffa, flo, tbit}), 8'h00, "flags in mid reset");
    rstn = 1'b1;
    repeat (3) tick();
    chk(rda | rdb, MAP_A_RST | MAP_B_RST, "map after reset");
    stop_test();
  end
endmodule
